// File: verilog/irh_pkg.sv
// Functional notes
// - SDA changes only while SCL is low; it holds steady while SCL is high.
// - Master creates every start and stop; falling or rising SDA with SCL high.
// - Each byte is eight bits, MSB first, followed by one acknowledge bit.
// - Receiver pulls SDA low in the ninth pulse to acknowledge; high means no.
// - First byte after start: 7-bit slave address MSB first, then 0 write 1 read.
// - Write transfer: two register address bytes follow, high byte then low byte.
// - Combined read: address write, repeated start, address with read, data bytes.
// - Master does not acknowledge the last read byte, then issues a stop.
// - In write mode the master stops in the pulse after the last data ack.
// - Master gives exactly one SCL pulse per bit, acknowledge bits included.
// - Read mode bytes are device data; master acks each byte it wants followed.
package irh_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W         = $clog2(QTR_CYC + 1);

  localparam int BYTE_W        = 8;
  localparam int LEN_W         = 16;
  localparam int FIFO_DEPTH    = 32;

  localparam logic [3:0] ACK_SLOT  = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic       DIR_WRITE = 1'b0;
  localparam logic       DIR_READ  = 1'b1;

  typedef enum logic [1:0] {
    IRH_CMD_WRITE    = 2'b00,
    IRH_CMD_SETPTR   = 2'b01,
    IRH_CMD_READ_CUR = 2'b10,
    IRH_CMD_READ_AT  = 2'b11
  } irh_cmd_t;

  typedef enum logic [2:0] {
    IRH_ST_IDLE  = 3'b000,
    IRH_ST_START = 3'b001,
    IRH_ST_TX    = 3'b010,
    IRH_ST_RX    = 3'b011,
    IRH_ST_LOAD  = 3'b100,
    IRH_ST_STOP  = 3'b101
  } irh_state_t;

  typedef enum logic [2:0] {
    IRH_PH_ADDR_W = 3'b000,
    IRH_PH_RA_HI  = 3'b001,
    IRH_PH_RA_LO  = 3'b010,
    IRH_PH_WDATA  = 3'b011,
    IRH_PH_ADDR_R = 3'b100,
    IRH_PH_RDATA  = 3'b101
  } irh_phase_t;

endpackage : irh_pkg

// File: verilog/irh_sync.sv
`timescale 1ns/1ps
`default_nettype none
module irh_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output var  logic o_sync
);

  logic meta_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      meta_reg <= RST_VAL;
      o_sync   <= RST_VAL;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule : irh_sync
`default_nettype wire

// File: verilog/irh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module irh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output var  logic             o_in_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output var  logic             o_out_valid,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cnt_next;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign cnt_next   = cnt_reg + CW'(push) - CW'(pop);
  assign o_out_data = mem[rd_ptr_reg];

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= i_in_data;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      cnt_reg     <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      cnt_reg     <= cnt_next;
      o_in_ready  <= (cnt_next != CW'(DEPTH));
      o_out_valid <= (cnt_next != '0);
    end
  end

endmodule : irh_fifo
`default_nettype wire

// File: verilog/irh_master.sv
`timescale 1ns/1ps
`default_nettype none
module irh_master #(
  parameter int LEN_W      = irh_pkg::LEN_W,
  parameter int FIFO_DEPTH = irh_pkg::FIFO_DEPTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_cmd_valid,
  input  wire logic [1:0]       i_cmd_kind,
  input  wire logic [6:0]       i_dev_addr,
  input  wire logic [15:0]      i_reg_addr,
  input  wire logic [LEN_W-1:0] i_len,
  output var  logic             o_cmd_ready,
  input  wire logic [7:0]       i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  output var  logic [7:0]       o_rd_data,
  output var  logic             o_rd_valid,
  output var  logic             o_busy,
  output var  logic             o_done,
  output var  logic             o_nack,
  input  wire logic             i_scl_in,
  output var  logic             o_scl_out,
  output var  logic             o_scl_oe_n,
  input  wire logic             i_sda_in,
  output var  logic             o_sda_out,
  output var  logic             o_sda_oe_n
);

  localparam int DW = irh_pkg::DIV_W;
  irh_pkg::irh_state_t state_reg, state_next;
  irh_pkg::irh_phase_t phase_reg, phase_next;
  irh_pkg::irh_cmd_t   kind_reg, kind_next;
  logic [6:0]          dev_reg, dev_next;
  logic [15:0]         addr_reg, addr_next;
  logic [LEN_W-1:0]    left_reg, left_next;
  logic [7:0]          shift_reg, shift_next;
  logic [3:0]          bit_reg, bit_next;
  logic [1:0]          q_reg, q_next;
  logic [DW-1:0]       div_reg, div_next;
  logic                rd_valid_next;
  logic [7:0]          rd_data_next;
  logic                done_next;
  logic                nack_next;
  logic                pop;
  logic                scl_low, sda_low;
  logic                scl_s, sda_s;
  logic [7:0]          f_data;
  logic                f_valid;

  irh_sync #(.RST_VAL (1'b1)) u_scl_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_scl_in),
    .o_sync    (scl_s)
  );
  irh_sync #(.RST_VAL (1'b1)) u_sda_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_sda_in),
    .o_sync    (sda_s)
  );

  irh_fifo #(.WIDTH (irh_pkg::BYTE_W), .DEPTH (FIFO_DEPTH)) u_wr_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_reset     (i_reset),
    .i_in_data   (i_wr_data),
    .i_in_valid  (i_wr_valid),
    .o_in_ready  (o_wr_ready),
    .o_out_data  (f_data),
    .o_out_valid (f_valid),
    .i_out_ready (pop)
  );

  // Hold the quarter timer while a released SCL is still seen low (slave stretching)
  wire stretch  = o_scl_oe_n && !scl_s;
  wire tick     = (div_reg == DW'(irh_pkg::QTR_CYC - 1)) && !stretch;
  wire end_bit  = tick && (q_reg == 2'h3);
  wire in_data  = (bit_reg < irh_pkg::ACK_SLOT);
  wire last_rd  = (left_reg <= LEN_W'(1));
  wire hold_sda = !o_sda_oe_n;
  wire scl_hi_q = (q_reg[1] == 1'b1);
  wire timed    = (state_reg != irh_pkg::IRH_ST_IDLE) && (state_reg != irh_pkg::IRH_ST_LOAD);
  wire wr_left  = (left_reg > LEN_W'(1));
  wire rd_cur   = (irh_pkg::irh_cmd_t'(i_cmd_kind) == irh_pkg::IRH_CMD_READ_CUR);

  // Pin levels per quarter: SDA moves in quarter 1 while SCL is low, and also in quarter 3 of START and STOP
  always_comb
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    case (state_reg)
      irh_pkg::IRH_ST_START:
      begin
        scl_low = !scl_hi_q;
        sda_low = (q_reg == 2'h0) ? hold_sda : (q_reg == 2'h3);
      end
      irh_pkg::IRH_ST_TX:
      begin
        scl_low = !scl_hi_q;
        if (q_reg == 2'h0)
          sda_low = hold_sda;
        else
          sda_low = in_data && !shift_reg[7];
      end
      irh_pkg::IRH_ST_RX:
      begin
        scl_low = !scl_hi_q;
        if (q_reg == 2'h0)
          sda_low = hold_sda;
        else
          sda_low = !in_data && !last_rd;
      end
      irh_pkg::IRH_ST_LOAD:
      begin
        scl_low = 1'b1;
        sda_low = hold_sda;
      end
      irh_pkg::IRH_ST_STOP:
      begin
        scl_low = !scl_hi_q;
        sda_low = (q_reg == 2'h0) ? hold_sda : (q_reg != 2'h3);
      end
      default:
        scl_low = 1'b0;
    endcase
  end

  always_comb
  begin
    state_next    = state_reg;
    phase_next    = phase_reg;
    kind_next     = kind_reg;
    dev_next      = dev_reg;
    addr_next     = addr_reg;
    left_next     = left_reg;
    shift_next    = shift_reg;
    bit_next      = bit_reg;
    rd_valid_next = 1'b0;
    rd_data_next  = o_rd_data;
    done_next     = 1'b0;
    nack_next     = 1'b0;
    pop           = 1'b0;
    case (state_reg)
      irh_pkg::IRH_ST_IDLE:
      begin
        if (i_cmd_valid)
        begin
          kind_next  = irh_pkg::irh_cmd_t'(i_cmd_kind);
          dev_next   = i_dev_addr;
          addr_next  = i_reg_addr;
          left_next  = i_len;
          bit_next   = 4'h0;
          state_next = irh_pkg::IRH_ST_START;
          shift_next = {i_dev_addr, rd_cur ? irh_pkg::DIR_READ : irh_pkg::DIR_WRITE};
          phase_next = rd_cur ? irh_pkg::IRH_PH_ADDR_R : irh_pkg::IRH_PH_ADDR_W;
        end
      end
      irh_pkg::IRH_ST_START:
      begin
        if (end_bit)
        begin
          bit_next   = 4'h0;
          state_next = irh_pkg::IRH_ST_TX;
        end
      end
      irh_pkg::IRH_ST_TX:
      begin
        if (end_bit && in_data)
        begin
          shift_next = {shift_reg[6:0], 1'b0};
          bit_next   = bit_reg + 4'h1;
        end
        else if (end_bit && sda_s)
        begin
          nack_next  = 1'b1;
          state_next = irh_pkg::IRH_ST_STOP;
        end
        else if (end_bit)
        begin
          bit_next = 4'h0;
          case (phase_reg)
            irh_pkg::IRH_PH_ADDR_W:
            begin
              shift_next = addr_reg[15:8];
              phase_next = irh_pkg::IRH_PH_RA_HI;
            end
            irh_pkg::IRH_PH_RA_HI:
            begin
              shift_next = addr_reg[7:0];
              phase_next = irh_pkg::IRH_PH_RA_LO;
            end
            irh_pkg::IRH_PH_RA_LO:
            begin
              if (kind_reg == irh_pkg::IRH_CMD_READ_AT)
              begin
                shift_next = {dev_reg, irh_pkg::DIR_READ};
                phase_next = irh_pkg::IRH_PH_ADDR_R;
                state_next = irh_pkg::IRH_ST_START;
              end
              else if (kind_reg == irh_pkg::IRH_CMD_WRITE && left_reg != '0)
              begin
                phase_next = irh_pkg::IRH_PH_WDATA;
                state_next = irh_pkg::IRH_ST_LOAD;
              end
              else
                state_next = irh_pkg::IRH_ST_STOP;
            end
            irh_pkg::IRH_PH_WDATA:
            begin
              left_next = left_reg - LEN_W'(1);
              if (wr_left)
                state_next = irh_pkg::IRH_ST_LOAD;
              else
                state_next = irh_pkg::IRH_ST_STOP;
            end
            irh_pkg::IRH_PH_ADDR_R:
            begin
              phase_next = irh_pkg::IRH_PH_RDATA;
              state_next = irh_pkg::IRH_ST_RX;
            end
            default:
              state_next = irh_pkg::IRH_ST_STOP;
          endcase
        end
      end
      irh_pkg::IRH_ST_LOAD:
      begin
        if (f_valid)
        begin
          pop        = 1'b1;
          shift_next = f_data;
          bit_next   = 4'h0;
          state_next = irh_pkg::IRH_ST_TX;
        end
      end
      irh_pkg::IRH_ST_RX:
      begin
        if (end_bit && in_data)
        begin
          shift_next = {shift_reg[6:0], sda_s};
          bit_next   = bit_reg + 4'h1;
          if (bit_reg == irh_pkg::LAST_BIT)
          begin
            rd_data_next  = {shift_reg[6:0], sda_s};
            rd_valid_next = 1'b1;
          end
        end
        else if (end_bit)
        begin
          bit_next = 4'h0;
          if (last_rd)
            state_next = irh_pkg::IRH_ST_STOP;
          else
            left_next = left_reg - LEN_W'(1);
        end
      end
      irh_pkg::IRH_ST_STOP:
      begin
        if (end_bit)
        begin
          done_next  = 1'b1;
          state_next = irh_pkg::IRH_ST_IDLE;
        end
      end
      default:
        state_next = irh_pkg::IRH_ST_IDLE;
    endcase
  end

  // Quarter timer restarts at every change of state
  wire restart = !timed || (state_next != state_reg);
  assign div_next = (restart || tick) ? '0 : (stretch ? div_reg : div_reg + DW'(1));
  assign q_next   = restart ? 2'h0 : (tick ? q_reg + 2'h1 : q_reg);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      state_reg <= irh_pkg::IRH_ST_IDLE;
      phase_reg <= irh_pkg::IRH_PH_ADDR_W;
      kind_reg  <= irh_pkg::IRH_CMD_WRITE;
      dev_reg   <= 7'h00;
      addr_reg  <= 16'h0000;
      left_reg  <= '0;
      shift_reg <= 8'h00;
      bit_reg   <= 4'h0;
      q_reg     <= 2'h0;
      div_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      kind_reg  <= kind_next;
      dev_reg   <= dev_next;
      addr_reg  <= addr_next;
      left_reg  <= left_next;
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      q_reg     <= q_next;
      div_reg   <= div_next;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_cmd_ready <= 1'b0;
      o_busy      <= 1'b0;
      o_done      <= 1'b0;
      o_nack      <= 1'b0;
      o_rd_valid  <= 1'b0;
      o_rd_data   <= 8'h00;
      o_scl_out   <= 1'b0;
      o_scl_oe_n  <= 1'b1;
      o_sda_out   <= 1'b0;
      o_sda_oe_n  <= 1'b1;
    end
    else
    begin
      o_cmd_ready <= (state_next == irh_pkg::IRH_ST_IDLE);
      o_busy      <= (state_next != irh_pkg::IRH_ST_IDLE);
      o_done      <= done_next;
      o_nack      <= nack_next;
      o_rd_valid  <= rd_valid_next;
      o_rd_data   <= rd_data_next;
      o_scl_out   <= 1'b0;
      o_scl_oe_n  <= !scl_low;
      o_sda_out   <= 1'b0;
      o_sda_oe_n  <= !sda_low;
    end
  end

endmodule : irh_master
`default_nettype wire

// File: sim/irh_master_sva.sv
`timescale 1ns/1ps
`default_nettype none
module irh_master_sva (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic o_cmd_ready,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_nack,
  input wire logic o_rd_valid,
  input wire logic o_scl_out,
  input wire logic o_sda_out,
  input wire logic o_scl_oe_n,
  input wire logic o_sda_oe_n
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  a_lines_open_drain:
    assert property (!o_scl_out && !o_sda_out) else $error("line driven high");
  a_sda_still_rise:
    assert property ($rose(o_scl_oe_n) |-> $stable(o_sda_oe_n)) else $error("sda moved at rise");
  a_sda_still_fall:
    assert property ($fell(o_scl_oe_n) |-> $stable(o_sda_oe_n)) else $error("sda moved at fall");
  a_stop_then_done:
    assert property ($rose(o_sda_oe_n) && o_scl_oe_n |-> ##[1:40] o_done) else $error("no done");
  a_start_holds:
    assert property ($fell(o_sda_oe_n) && o_scl_oe_n |-> (o_scl_oe_n && !o_sda_oe_n) [*8]
      ##[1:20] !o_scl_oe_n) else $error("start shape wrong");
  a_cmd_opens_frame:
    assert property (i_cmd_valid && o_cmd_ready |=> (o_busy && !o_cmd_ready)
      ##[1:80] ($fell(o_sda_oe_n) && o_scl_oe_n)) else $error("no start after command");
  a_nack_stops:
    assert property (o_nack |-> ##[1:300] o_done) else $error("no stop after nack");
  a_rd_one_pulse:
    assert property (o_rd_valid |-> o_busy ##1 !o_rd_valid [*8]) else $error("read pulse wrong");
  a_idle_released:
    assert property (o_cmd_ready |-> o_scl_oe_n && o_sda_oe_n) else $error("bus held when idle");
  cover property (o_nack);
  cover property (o_rd_valid);
  cover property (o_done && !o_nack);
endmodule : irh_master_sva

bind irh_master irh_master_sva u_sva (
  .i_sys_clk, .i_reset, .i_cmd_valid, .o_cmd_ready, .o_busy, .o_done, .o_nack,
  .o_rd_valid, .o_scl_out, .o_sda_out, .o_scl_oe_n, .o_sda_oe_n
);
`default_nettype wire

// File: sim/irh_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module irh_slave_model #(
  parameter logic [6:0] SLV_ADDR = 7'h2A  // arbitrary pick among the seven
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  var  int   i_stretch_ns,
  output var  logic o_scl_oe_n,
  output var  logic o_sda_oe_n
);
  logic [7:0]  mem [256];
  logic [7:0]  sh = 8'h00;
  logic [15:0] ptr = 16'h0000;
  logic        act = 1'b0;
  logic        tx = 1'b0;
  logic        mack = 1'b0;
  int          bitn = 0;
  int          ph = 0;
  logic        sda_nx = 1'b1;
  // The device is a pure slave and never pulls SCL
  assign o_scl_oe_n = 1'b1;
  initial o_sda_oe_n = 1'b1;
  // Start or repeated start drops any partial byte
  always @(negedge i_sda)
    if (i_scl === 1'b1)
    begin
      act = 1'b1;
      bitn = -1;
      ph = 0;
      tx = 1'b0;
      o_sda_oe_n = 1'b1;
    end
  always @(posedge i_sda)
    if (i_scl === 1'b1)
    begin
      act = 1'b0;
      o_sda_oe_n = 1'b1;
    end
  always @(posedge i_scl)
    if (act && bitn < 8 && !tx)
      sh = {sh[6:0], i_sda};
    else if (act && bitn == 8)
      mack = !i_sda;
  always @(negedge i_scl)
    if (act)
    begin
      if (bitn == 7 && !tx)
      begin
        act = (ph != 0) || (sh[7:1] == SLV_ADDR);
        sda_nx = !act;
        if (ph == 1 || ph == 2)
          ptr = {ptr[7:0], sh};
        // Update bit clears itself; no separate active copy is kept
        if (ph == 3)
        begin
          mem[ptr[7:0]] = (ptr == 16'h000F) ? (sh & 8'hFE) : sh;
          ptr = ptr + 16'h0001;
        end
        if (ph == 0)
          ph = sh[0] ? 4 : 1;
        else if (ph < 3)
          ph = ph + 1;
      end
      else if (bitn == 8)
      begin
        act = !(tx && !mack);
        tx = act && ph == 4;
        sh = mem[ptr[7:0]];
        if (tx)
          ptr = ptr + 16'h0001;
        sda_nx = !tx || sh[7];
      end
      else
        sda_nx = !tx || bitn == 7 || sh[6 - bitn];
      bitn = (bitn == 8) ? 0 : bitn + 1;
      // Slow answer: the new SDA level shows up late, still inside the low phase
      if (i_stretch_ns > 0)
        #(i_stretch_ns);
      o_sda_oe_n = sda_nx;
    end
endmodule : irh_slave_model
`default_nettype wire

// File: sim/tb_irh_master.sv
`timescale 1ns/1ps
`default_nettype none
module tb_irh_master;
  localparam logic [6:0] DEV = 7'h2A;
  logic        i_sys_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_cmd_valid = 1'b0;
  logic [1:0]  i_cmd_kind = 2'h0;
  logic [6:0]  i_dev_addr = 7'h00;
  logic [15:0] i_reg_addr = 16'h0000;
  logic [15:0] i_len = 16'h0000;
  logic [7:0]  i_wr_data = 8'h00;
  logic        i_wr_valid = 1'b0;
  logic [7:0]  o_rd_data;
  logic        o_cmd_ready, o_wr_ready, o_rd_valid, o_busy, o_done, o_nack;
  logic        o_scl_out, o_scl_oe_n, o_sda_out, o_sda_oe_n, m_scl_oe_n, m_sda_oe_n, nk;
  wire logic   scl_w;
  wire logic   sda_w;
  int          stretch_ns = 0;
  int          err_count = 0;
  int          checks = 0;
  logic [7:0]  rq [$];
  // Pulled-up wires
  assign scl_w = o_scl_oe_n & m_scl_oe_n;
  assign sda_w = o_sda_oe_n & m_sda_oe_n;
  irh_master dut (
    .i_sys_clk, .i_reset, .i_cmd_valid, .i_cmd_kind, .i_dev_addr, .i_reg_addr, .i_len,
    .o_cmd_ready, .i_wr_data, .i_wr_valid, .o_wr_ready, .o_rd_data, .o_rd_valid, .o_busy,
    .o_done, .o_nack, .i_scl_in(scl_w), .o_scl_out, .o_scl_oe_n, .i_sda_in(sda_w),
    .o_sda_out, .o_sda_oe_n
  );
  irh_slave_model #(.SLV_ADDR(DEV)) u_dev (
    .i_scl(scl_w), .i_sda(sda_w), .i_stretch_ns(stretch_ns), .o_scl_oe_n(m_scl_oe_n),
    .o_sda_oe_n(m_sda_oe_n)
  );
  always #20 i_sys_clk = ~i_sys_clk;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk1

  // Issue one command and collect read bytes until done
  task automatic run(input logic [1:0] k, input logic [6:0] da, input logic [15:0] ra,
                     input logic [15:0] n);
    int t;
    t = 0;
    rq.delete();
    nk = 1'b0;
    i_cmd_kind <= k;
    i_dev_addr <= da;
    i_reg_addr <= ra;
    i_len <= n;
    i_cmd_valid <= 1'b1;
    @(posedge i_sys_clk);
    while (o_cmd_ready !== 1'b1)
      @(posedge i_sys_clk);
    i_cmd_valid <= 1'b0;
    while (o_done !== 1'b1 && t < 60000)
    begin
      @(posedge i_sys_clk);
      t++;
      if (o_rd_valid === 1'b1)
        rq.push_back(o_rd_data);
      if (o_nack === 1'b1)
        nk = 1'b1;
    end
    chk1(o_done, 1'b1);
  endtask : run

  task automatic t_stream;
    int i;
    i_wr_valid <= 1'b1;
    for (i = 0; i < 32; i++)
    begin
      i_wr_data <= 8'h40 + 8'(i);
      @(posedge i_sys_clk);
    end
    i_wr_valid <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    chk1(o_wr_ready, 1'b0);
    stretch_ns = 1000;
    run(2'h0, DEV, 16'h0020, 16'h0020);
    stretch_ns = 0;
    chk1(nk, 1'b0);
    chk1(o_wr_ready, 1'b1);
    run(2'h3, DEV, 16'h0020, 16'h0020);
    chk1(rq.size() == 32, 1'b1);
    for (i = 0; i < 32; i++)
      chk8(rq[i], 8'h40 + 8'(i));
    $display("test stream done");
  endtask : t_stream

  task automatic t_ptr;
    run(2'h1, DEV, 16'h0025, 16'h0000);
    stretch_ns = 1000;
    run(2'h2, DEV, 16'h0000, 16'h0002);
    stretch_ns = 0;
    chk1(rq.size() == 2, 1'b1);
    chk8(rq[0], 8'h45);
    chk8(rq[1], 8'h46);
    run(2'h2, DEV, 16'h0000, 16'h0000);
    chk8(rq[0], 8'h47);
    $display("test pointer done");
  endtask : t_ptr

  task automatic t_nack;
    run(2'h2, DEV ^ 7'h01, 16'h0000, 16'h0001);
    chk1(nk, 1'b1);
    chk1(rq.size() == 0, 1'b1);
    run(2'h2, DEV, 16'h0000, 16'h0001);
    chk1(nk, 1'b0);
    chk8(rq[0], 8'h48);
    $display("test nack done");
  endtask : t_nack

  task automatic t_update;
    i_wr_valid <= 1'b1;
    i_wr_data <= 8'h5A;
    @(posedge i_sys_clk);
    i_wr_data <= 8'h01;
    @(posedge i_sys_clk);
    i_wr_valid <= 1'b0;
    run(2'h0, DEV, 16'h000E, 16'h0002);
    run(2'h3, DEV, 16'h000E, 16'h0002);
    chk8(rq[0], 8'h5A);
    chk8(rq[1], 8'h00);
    $display("test update done");
  endtask : t_update

  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    t_stream();
    t_ptr();
    t_nack();
    t_update();
    final_report();
  end

  // Tests need about 55k cycles of bus time
  initial
  begin
    #3_900_000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule : tb_irh_master
`default_nettype wire
